// >>> design/alu8.sv
module alu8 import exec_pkg::*; (
  alu_if.alu bus
);
  wire [8:0] sum = 9'({1'b0, bus.a} + {1'b0, bus.b} + {8'h00, bus.cin});
  wire [8:0] diff = 9'({1'b0, bus.a} - {1'b0, bus.b} - {8'h00, bus.cin});
  wire [4:0] sumLow = 5'({1'b0, bus.a[3:0]} + {1'b0, bus.b[3:0]} + {4'h0, bus.cin});
  wire [4:0] subLow = 5'({1'b0, bus.b[3:0]} + {4'h0, bus.cin});
  wire [7:0] bitMask = 8'(8'h01 << bus.bitIdx);

  always_comb begin
    bus.result = bus.b;
    bus.cout = bus.cin;
    bus.auxCarry = 1'b0;
    bus.overflow = 1'b0;
    unique case (bus.op)
      ALU_PASS: bus.result = bus.b;
      ALU_ADD: begin
        bus.result = sum[7:0];
        bus.cout = sum[8];
        bus.auxCarry = sumLow[4];
        bus.overflow = (bus.a[7] == bus.b[7]) && (sum[7] != bus.a[7]);
      end
      ALU_SUB: begin
        // Carry out is the borrow: set when the result went below zero
        bus.result = diff[7:0];
        bus.cout = diff[8];
        bus.auxCarry = {1'b0, bus.a[3:0]} < subLow;
        bus.overflow = (bus.a[7] != bus.b[7]) && (diff[7] != bus.a[7]);
      end
      ALU_AND: bus.result = bus.a & bus.b;
      ALU_OR: bus.result = bus.a | bus.b;
      ALU_XOR: bus.result = bus.a ^ bus.b;
      ALU_NOT: bus.result = ~bus.b;
      ALU_INC: bus.result = 8'(bus.b + 8'h01);
      ALU_DEC: bus.result = 8'(bus.b - 8'h01);
      ALU_ROTL: bus.result = {bus.b[6:0], bus.b[7]};
      ALU_ROTR: bus.result = {bus.b[0], bus.b[7:1]};
      ALU_ROTLC: begin
        bus.result = {bus.b[6:0], bus.cin};
        bus.cout = bus.b[7];
      end
      ALU_ROTRC: begin
        bus.result = {bus.cin, bus.b[7:1]};
        bus.cout = bus.b[0];
      end
      ALU_SETB: bus.result = bus.b | bitMask;
      ALU_CLRB: bus.result = bus.b & ~bitMask;
    endcase
  end

  assign bus.zero = (bus.result == BYTE_ZERO);
endmodule // alu8

// >>> design/instr_exec_core.sv
module instr_exec_core import exec_pkg::*; (
  input wire logic clk_sys,
  input wire logic rst,
  output logic [PC_W-1:0] progAddr,
  input wire logic [15:0] progData,
  output logic [7:0] memRdAddr,
  input wire logic [7:0] memRdData,
  output logic [7:0] memWrAddr,
  output logic [7:0] memWrData,
  output logic memWrEn,
  input wire logic wakeUp,
  output logic powerDown,
  output logic wdtClear,
  output logic intEnable,
  output logic [7:0] accOut,
  output logic [3:0] flagsOut,
  output logic [7:0] tableHigh,
  output logic [PC_W-1:0] pcOut,
  output logic instrDone
);
  typedef enum logic [1:0] {ST_EXEC, ST_SECOND, ST_HALT} state_type;

  state_type stateReg, stateNext;
  logic [1:0] phaseReg;
  logic [PC_W-1:0] pcReg, pcNext;
  logic [7:0] accReg;
  logic zFlag, cFlag, acFlag, ovFlag;
  logic [PC_W-1:0] stackMem [STACK_DEPTH];
  logic [SP_W-1:0] spReg;
  logic tableRdReg;
  logic [7:0] tableDestReg;

  alu_if aluBus ();
  alu8 aluUnit (.bus(aluBus));

  // Clock divider: one enable pulse every four system clocks, held at phase zero with no pulses while halted
  wire cycleEn = (phaseReg == PHASE_LAST);
  wire execEn = cycleEn && (stateReg == ST_EXEC);

  wire [OP_W-1:0] op = progData[15:11];
  wire [2:0] bitIdx = progData[10:8];
  wire [7:0] opnd = progData[7:0];
  wire [1:0] miscCode = progData[1:0];
  wire immOp = (op == OP_MOV_AX) || (op == OP_ADD_AX) || (op == OP_SUB_AX);
  wire [7:0] memData = (opnd == PCL_ADDR) ? pcReg[7:0] : memRdData;
  wire [7:0] bOperand = immOp ? opnd : memData;
  wire [PC_W-1:0] tableAddr = {TABLE_PAGE, accReg};
  wire [PC_W-1:0] retAddr = stackMem[SP_W'(spReg - 3'h1)];

  logic [3:0] aluOp;
  logic toAcc, toMem, arithFlags, zeroOnly, carryOnly, withCarry;
  always_comb begin
    aluOp = ALU_PASS;
    toAcc = 1'b0;
    toMem = 1'b0;
    arithFlags = 1'b0;
    zeroOnly = 1'b0;
    carryOnly = 1'b0;
    withCarry = 1'b0;
    unique case (op)
      OP_MOV_AM, OP_MOV_AX: toAcc = 1'b1;
      OP_MOV_MA: toMem = 1'b1;
      OP_ADD_AM, OP_ADD_AX: {aluOp, toAcc, arithFlags} = {ALU_ADD, 2'b11};
      OP_ADDM: {aluOp, toMem, arithFlags} = {ALU_ADD, 2'b11};
      OP_ADC_AM: {aluOp, toAcc, arithFlags, withCarry} = {ALU_ADD, 3'b111};
      OP_SUB_AM, OP_SUB_AX: {aluOp, toAcc, arithFlags} = {ALU_SUB, 2'b11};
      OP_SBC_AM: {aluOp, toAcc, arithFlags, withCarry} = {ALU_SUB, 3'b111};
      OP_AND_AM: {aluOp, toAcc, zeroOnly} = {ALU_AND, 2'b11};
      OP_OR_AM: {aluOp, toAcc, zeroOnly} = {ALU_OR, 2'b11};
      OP_XOR_AM: {aluOp, toAcc, zeroOnly} = {ALU_XOR, 2'b11};
      OP_COMPLEMENT: {aluOp, toMem, zeroOnly} = {ALU_NOT, 2'b11};
      OP_COMPLEMENT_A: {aluOp, toAcc, zeroOnly} = {ALU_NOT, 2'b11};
      OP_INC_M: {aluOp, toMem, zeroOnly} = {ALU_INC, 2'b11};
      OP_INC_A: {aluOp, toAcc, zeroOnly} = {ALU_INC, 2'b11};
      OP_DEC_M: {aluOp, toMem, zeroOnly} = {ALU_DEC, 2'b11};
      OP_DEC_A: {aluOp, toAcc, zeroOnly} = {ALU_DEC, 2'b11};
      OP_ROTATE: begin
        unique case ({progData[ROT_CARRY_BIT], progData[ROT_LEFT_BIT]})
          2'b00: aluOp = ALU_ROTR;
          2'b01: aluOp = ALU_ROTL;
          2'b10: aluOp = ALU_ROTRC;
          2'b11: aluOp = ALU_ROTLC;
        endcase
        toAcc = progData[ROT_TO_ACC_BIT];
        toMem = !progData[ROT_TO_ACC_BIT];
        carryOnly = progData[ROT_CARRY_BIT];
        withCarry = progData[ROT_CARRY_BIT];
      end
      OP_SET_BIT: {aluOp, toMem} = {ALU_SETB, 1'b1};
      OP_CLR_BIT: {aluOp, toMem} = {ALU_CLRB, 1'b1};
      OP_SKIP_INC: {aluOp, toMem} = {ALU_INC, 1'b1};
      OP_SKIP_DEC: {aluOp, toMem} = {ALU_DEC, 1'b1};
      default: aluOp = ALU_PASS;
    endcase
  end

  assign aluBus.op = alu_op_type'(aluOp);
  assign aluBus.a = accReg;
  assign aluBus.b = (op == OP_MOV_MA) ? accReg : bOperand;
  assign aluBus.bitIdx = bitIdx;
  assign aluBus.cin = withCarry && cFlag;

  wire skipOp = (op == OP_SKIP_Z) || (op == OP_SKIP_BZ) || (op == OP_SKIP_BNZ) ||
    (op == OP_SKIP_INC) || (op == OP_SKIP_DEC);
  // Byte test, bit test, or test of the incremented or decremented value
  wire skipTaken = ((op == OP_SKIP_Z) && (memData == BYTE_ZERO)) ||
    ((op == OP_SKIP_BZ) && !memData[bitIdx]) || ((op == OP_SKIP_BNZ) && memData[bitIdx]) ||
    (((op == OP_SKIP_INC) || (op == OP_SKIP_DEC)) && aluBus.zero);
  wire pclWrite = toMem && (opnd == PCL_ADDR);
  wire isReturn = (op == OP_MISC) && ((miscCode == MISC_RET) || (miscCode == MISC_INTERRUPT_RETURN_OP));
  wire ctrlXfer = (op == OP_JUMP) || (op == OP_CALL) || isReturn;
  wire needSecond = ctrlXfer || (op == OP_TABLE_RD) || pclWrite || skipTaken;
  wire enterHalt = (op == OP_MISC) && (miscCode == MISC_HALT);

  always_comb begin
    pcNext = PC_W'(pcReg + PC_STEP);
    if (op == OP_JUMP || op == OP_CALL) begin
      pcNext = progData[PC_W-1:0];
    end else if (isReturn) begin
      pcNext = retAddr;
    end else if (pclWrite) begin
      pcNext = {pcReg[PC_W-1:8], aluBus.result};
    end else if (skipTaken) begin
      pcNext = PC_W'(pcReg + PC_SKIP);
    end
  end

  always_comb begin
    stateNext = stateReg;
    unique case (stateReg)
      ST_EXEC: if (execEn) stateNext = needSecond ? ST_SECOND : (enterHalt ? ST_HALT : ST_EXEC);
      ST_SECOND: if (cycleEn) stateNext = ST_EXEC;
      ST_HALT: if (wakeUp) stateNext = ST_EXEC;
    endcase
  end

  assign progAddr = (stateReg == ST_SECOND && tableRdReg) ? tableAddr : pcReg;
  assign memRdAddr = opnd;
  assign accOut = accReg;
  assign flagsOut = {ovFlag, acFlag, cFlag, zFlag};
  assign pcOut = pcReg;
  assign powerDown = (stateReg == ST_HALT);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      phaseReg <= 2'h0;
      stateReg <= ST_EXEC;
    end else begin
      phaseReg <= (stateReg == ST_HALT) ? 2'h0 : 2'(phaseReg + 2'h1);
      stateReg <= stateNext;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pcReg <= PC_RESET;
      accReg <= BYTE_ZERO;
      {zFlag, cFlag, acFlag, ovFlag} <= 4'h0;
      spReg <= 3'h0;
      intEnable <= 1'b0;
      tableRdReg <= 1'b0;
      tableDestReg <= BYTE_ZERO;
    end else if (execEn) begin
      pcReg <= pcNext;
      tableRdReg <= (op == OP_TABLE_RD);
      tableDestReg <= opnd;
      if (toAcc) accReg <= aluBus.result;
      if (arithFlags || zeroOnly) zFlag <= aluBus.zero;
      if (arithFlags || carryOnly) cFlag <= aluBus.cout;
      if (arithFlags) {acFlag, ovFlag} <= {aluBus.auxCarry, aluBus.overflow};
      if (op == OP_CALL) spReg <= SP_W'(spReg + 3'h1);
      if (isReturn) spReg <= SP_W'(spReg - 3'h1);
      if (op == OP_MISC && miscCode == MISC_INTERRUPT_RETURN_OP) intEnable <= 1'b1;
    end else if (cycleEn && stateReg == ST_SECOND) begin
      tableRdReg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (execEn && op == OP_CALL) stackMem[spReg] <= PC_W'(pcReg + PC_STEP);
  end

  // Registered data memory write port; table data also lands here
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      memWrEn <= 1'b0;
      memWrAddr <= BYTE_ZERO;
      memWrData <= BYTE_ZERO;
      tableHigh <= BYTE_ZERO;
      wdtClear <= 1'b0;
      instrDone <= 1'b0;
    end else begin
      memWrEn <= 1'b0;
      wdtClear <= execEn && (op == OP_MISC) && (miscCode == MISC_CLRWDT);
      instrDone <= (execEn && !needSecond) || (cycleEn && stateReg == ST_SECOND);
      if (execEn && toMem && !pclWrite) begin
        memWrEn <= 1'b1;
        memWrAddr <= opnd;
        memWrData <= aluBus.result;
      end else if (cycleEn && stateReg == ST_SECOND && tableRdReg) begin
        memWrEn <= 1'b1;
        memWrAddr <= tableDestReg;
        memWrData <= progData[7:0];
        tableHigh <= progData[15:8];
      end
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  cycle_four_clk_a: assert property ((cycleEn && !(execEn && enterHalt)) |=> !cycleEn [*3] ##1 cycleEn)
    else $error("instruction cycle not four clocks");
  jump_extra_cycle_a: assert property ((execEn && ctrlXfer) |=> (stateReg == ST_SECOND) [*4] ##1
    (stateReg == ST_EXEC)) else $error("control transfer not two cycles");
  single_cycle_a: assert property ((execEn && !needSecond && !enterHalt) |=>
    (stateReg == ST_EXEC) [*4] ##0 cycleEn) else $error("plain instruction took extra cycle");
  call_return_pt_a: assert property ((execEn && op == OP_CALL) |=>
    (stackMem[$past(spReg)] == $past(pcReg) + PC_STEP)) else $error("call lost return point");
  ret_resume_a: assert property ((execEn && isReturn) |=> (pcReg == $past(retAddr)))
    else $error("return went to wrong address");
  pcl_jump_a: assert property ((execEn && pclWrite) |=> (pcReg[7:0] == $past(aluBus.result)) &&
    (stateReg == ST_SECOND) && !memWrEn) else $error("low pc write not a jump");
  skip_taken_a: assert property ((execEn && skipOp && skipTaken && !pclWrite) |=>
    (pcReg == $past(pcReg) + PC_SKIP) && (stateReg == ST_SECOND)) else $error("skip timing wrong");
  no_skip_a: assert property ((execEn && skipOp && !skipTaken && !pclWrite) |=>
    (pcReg == $past(pcReg) + PC_STEP) && (stateReg == ST_EXEC)) else $error("untaken skip slow");
  add_carry_a: assert property ((execEn && op == OP_ADD_AM) |=>
    (cFlag == ({1'b0, $past(accReg)} + {1'b0, $past(bOperand)} > {1'b0, BYTE_MAX})))
    else $error("add carry wrong");
  inc_by_one_a: assert property ((execEn && op == OP_INC_A) |=> (accReg == 8'($past(bOperand) + 8'h01)))
    else $error("increment not by one");
  logic_zero_a: assert property ((execEn && zeroOnly && toAcc) |=> (zFlag == (accReg == BYTE_ZERO)))
    else $error("zero flag wrong");
  bit_only_a: assert property ((execEn && op == OP_SET_BIT && !pclWrite) |=> memWrEn &&
    ((memWrData ^ $past(memData)) == (8'h01 << $past(bitIdx)) || memWrData == $past(memData)))
    else $error("bit set touched other bits");
endmodule // instr_exec_core

// >>> inc/alu_if.sv
interface alu_if;
  import exec_pkg::*;
  alu_op_type op;
  logic [DATA_W-1:0] a;
  logic [DATA_W-1:0] b;
  logic [2:0] bitIdx;
  logic cin;
  logic [DATA_W-1:0] result;
  logic cout;
  logic auxCarry;
  logic overflow;
  logic zero;
  modport core (output op, a, b, bitIdx, cin, input result, cout, auxCarry, overflow, zero);
  modport alu (input op, a, b, bitIdx, cin, output result, cout, auxCarry, overflow, zero);
endinterface

// >>> inc/exec_pkg.sv
package exec_pkg;
  localparam int DATA_W = 8;
  localparam int PC_W = 11;
  localparam int OP_W = 5;
  localparam int SP_W = 3;
  localparam int STACK_DEPTH = 8;
  localparam logic [1:0] PHASE_LAST = 2'h3;
  localparam logic [7:0] PCL_ADDR = 8'h02;
  localparam logic [2:0] TABLE_PAGE = 3'h7;
  localparam logic [PC_W-1:0] PC_RESET = 11'h000;
  localparam logic [PC_W-1:0] PC_STEP = 11'h001;
  localparam logic [PC_W-1:0] PC_SKIP = 11'h002;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_MAX = 8'hFF;
  localparam logic [3:0] NIB_MAX = 4'hF;
  // Instruction word: [15:11] opcode, [10:8] bit index / sub-field, [7:0] address or immediate
  localparam logic [OP_W-1:0] OP_NOP = 5'h00;
  localparam logic [OP_W-1:0] OP_MOV_AM = 5'h01;
  localparam logic [OP_W-1:0] OP_MOV_MA = 5'h02;
  localparam logic [OP_W-1:0] OP_MOV_AX = 5'h03;
  localparam logic [OP_W-1:0] OP_ADD_AM = 5'h04;
  localparam logic [OP_W-1:0] OP_ADDM = 5'h05;
  localparam logic [OP_W-1:0] OP_ADD_AX = 5'h06;
  localparam logic [OP_W-1:0] OP_ADC_AM = 5'h07;
  localparam logic [OP_W-1:0] OP_SUB_AM = 5'h08;
  localparam logic [OP_W-1:0] OP_SUB_AX = 5'h09;
  localparam logic [OP_W-1:0] OP_SBC_AM = 5'h0A;
  localparam logic [OP_W-1:0] OP_AND_AM = 5'h0B;
  localparam logic [OP_W-1:0] OP_OR_AM = 5'h0C;
  localparam logic [OP_W-1:0] OP_XOR_AM = 5'h0D;
  localparam logic [OP_W-1:0] OP_COMPLEMENT = 5'h0E;
  localparam logic [OP_W-1:0] OP_COMPLEMENT_A = 5'h0F;
  localparam logic [OP_W-1:0] OP_INC_M = 5'h10;
  localparam logic [OP_W-1:0] OP_INC_A = 5'h11;
  localparam logic [OP_W-1:0] OP_DEC_M = 5'h12;
  localparam logic [OP_W-1:0] OP_DEC_A = 5'h13;
  localparam logic [OP_W-1:0] OP_ROTATE = 5'h14;
  localparam logic [OP_W-1:0] OP_SET_BIT = 5'h15;
  localparam logic [OP_W-1:0] OP_CLR_BIT = 5'h16;
  localparam logic [OP_W-1:0] OP_SKIP_Z = 5'h17;
  localparam logic [OP_W-1:0] OP_SKIP_BZ = 5'h18;
  localparam logic [OP_W-1:0] OP_SKIP_BNZ = 5'h19;
  localparam logic [OP_W-1:0] OP_SKIP_INC = 5'h1A;
  localparam logic [OP_W-1:0] OP_SKIP_DEC = 5'h1B;
  localparam logic [OP_W-1:0] OP_JUMP = 5'h1C;
  localparam logic [OP_W-1:0] OP_CALL = 5'h1D;
  localparam logic [OP_W-1:0] OP_TABLE_RD = 5'h1E;
  localparam logic [OP_W-1:0] OP_MISC = 5'h1F;
  // Rotate sub-field bits
  localparam int ROT_LEFT_BIT = 8;
  localparam int ROT_CARRY_BIT = 9;
  localparam int ROT_TO_ACC_BIT = 10;
  // Misc sub-codes in [1:0]
  localparam logic [1:0] MISC_RET = 2'h0;
  localparam logic [1:0] MISC_INTERRUPT_RETURN_OP = 2'h1;
  localparam logic [1:0] MISC_HALT = 2'h2;
  localparam logic [1:0] MISC_CLRWDT = 2'h3;

  typedef enum logic [3:0] {
    ALU_PASS, ALU_ADD, ALU_SUB, ALU_AND, ALU_OR, ALU_XOR, ALU_NOT, ALU_INC, ALU_DEC,
    ALU_ROTL, ALU_ROTR, ALU_ROTLC, ALU_ROTRC, ALU_SETB, ALU_CLRB
  } alu_op_type;
endpackage

// >>> sim/mcu_instruction_execution_timing_tb.sv
module mcu_instruction_execution_timing_tb import exec_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic wakeUp = 1'b0;
  logic [PC_W-1:0] progAddr;
  logic [15:0] progData;
  logic [7:0] memRdAddr;
  logic [7:0] memRdData;
  logic [7:0] memWrAddr;
  logic [7:0] memWrData;
  logic memWrEn;
  logic powerDown;
  logic wdtClear;
  logic intEnable;
  logic [7:0] accOut;
  logic [3:0] flagsOut;
  logic [7:0] tableHigh;
  logic [PC_W-1:0] pcOut;
  logic instrDone;
  logic [15:0] prog [0:2047];
  logic [7:0] dmem [0:255];
  logic [15:0] code [$];
  logic [15:0] expv [$];
  int nErrors = 0;
  int nTests = 0;
  int wdtCount = 0;

  always #50 clk_sys = ~clk_sys;
  // Memories answer within the same clock
  assign progData = prog[progAddr];
  assign memRdData = dmem[memRdAddr];
  always @(posedge clk_sys) begin
    if (memWrEn === 1'b1) dmem[memWrAddr] <= memWrData;
    if (wdtClear === 1'b1) wdtCount <= wdtCount + 1;
  end

  instr_exec_core dut_u (.clk_sys(clk_sys), .rst(rst), .progAddr(progAddr), .progData(progData),
    .memRdAddr(memRdAddr), .memRdData(memRdData), .memWrAddr(memWrAddr), .memWrData(memWrData),
    .memWrEn(memWrEn), .wakeUp(wakeUp), .powerDown(powerDown), .wdtClear(wdtClear),
    .intEnable(intEnable), .accOut(accOut), .flagsOut(flagsOut), .tableHigh(tableHigh),
    .pcOut(pcOut), .instrDone(instrDone));

  function automatic logic [15:0] ins(input logic [4:0] op, input logic [2:0] sub, input logic [7:0] lo);
    return {op, sub, lo};
  endfunction

  task stopTest;
    $display("Checks %0d, mismatches %0d", nTests, nErrors);
    if (nErrors == 0 && nTests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    nTests++;
    if (seen !== exp) begin
      nErrors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task clearMem;
    for (int i = 0; i < 2048; i++) prog[i] = 16'h0000;
    for (int i = 0; i < 256; i++) dmem[i] = 8'h00;
  endtask

  task resetCore(input int n);
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (n) @(posedge clk_sys);
    rst <= 1'b0;
  endtask

  // Clocks since the previous call, up to the next completion pulse
  task waitDone(output int cyc);
    cyc = 0;
    do begin
      @(posedge clk_sys);
      #1;
      cyc++;
    end while (instrDone !== 1'b1 && cyc < 40);
    if (instrDone !== 1'b1) begin
      check("completion pulse", 16'h0000, 16'h0001);
      stopTest;
    end
  endtask

  // Runs the loaded code queue, comparing accumulator and masked flags per instruction
  task runTable;
    int cyc;
    for (int i = 0; i < code.size(); i++) prog[i] = code[i];
    resetCore(2);
    for (int i = 0; i < code.size(); i++) begin
      waitDone(cyc);
      check("accumulator", {8'h00, accOut}, {8'h00, expv[i][7:0]});
      check("flags", {12'h000, flagsOut & expv[i][15:12]}, {12'h000, expv[i][11:8]});
    end
    // Last memory write lands one clock after completion
    @(posedge clk_sys);
    #1;
  endtask

  task timingTest;
    int cyc;
    int lenExp [12] = '{0, 8, 8, 4, 8, 8, 4, 8, 8, 8, 8, 4};
    int pcExp [12] = '{1, 4, 6, 7, 20, 8, 9, 12, 13, 24, 14, 15};
    clearMem;
    prog[0] = ins(OP_MOV_AX, 3'h0, 8'h00);
    prog[1] = ins(OP_JUMP, 3'h0, 8'h04);
    prog[4] = ins(OP_SKIP_Z, 3'h0, 8'h10);
    prog[6] = ins(OP_SKIP_Z, 3'h0, 8'h11);
    prog[7] = ins(OP_CALL, 3'h0, 8'h14);
    prog[20] = ins(OP_MISC, 3'h0, {6'h00, MISC_RET});
    prog[8] = ins(OP_MOV_AX, 3'h0, 8'h0C);
    prog[9] = ins(OP_MOV_MA, 3'h0, PCL_ADDR);
    prog[12] = ins(OP_TABLE_RD, 3'h0, 8'h30);
    prog[13] = ins(OP_CALL, 3'h0, 8'h18);
    prog[24] = ins(OP_MISC, 3'h0, {6'h00, MISC_INTERRUPT_RETURN_OP});
    prog[11'h70C] = 16'hBEEF;
    dmem[8'h11] = 8'h05;
    resetCore(2);
    #1;
    check("interrupt enable at reset", {15'h0000, intEnable}, 16'h0000);
    for (int k = 0; k < 12; k++) begin
      waitDone(cyc);
      if (k > 0) check("instruction length", cyc[15:0], lenExp[k][15:0]);
      check("program counter", {5'h00, pcOut}, pcExp[k][15:0]);
    end
    check("table high byte", {8'h00, tableHigh}, 16'h00BE);
    check("table low byte", {8'h00, dmem[8'h30]}, 16'h00EF);
    check("no memory write at pc byte", {8'h00, dmem[PCL_ADDR]}, 16'h0000);
    check("interrupt enable", {15'h0000, intEnable}, 16'h0001);
    $display("timing test done");
  endtask

  task arithTest;
    clearMem;
    dmem[8'h20] = 8'h0F; dmem[8'h21] = 8'hF0; dmem[8'h22] = 8'h7F; dmem[8'h25] = 8'hFF;
    dmem[8'h26] = 8'hAA; dmem[8'h27] = 8'h12; dmem[8'h28] = 8'hF0;
    code = {ins(OP_MOV_AX, 3'h0, 8'hFF), ins(OP_ADD_AX, 3'h0, 8'h01), ins(OP_SUB_AX, 3'h0, 8'h01),
      ins(OP_ADD_AX, 3'h0, 8'h80), ins(OP_MOV_AM, 3'h0, 8'h20), ins(OP_AND_AM, 3'h0, 8'h21),
      ins(OP_INC_A, 3'h0, 8'h22), ins(OP_DEC_M, 3'h0, 8'h23), ins(OP_XOR_AM, 3'h0, 8'h21),
      ins(OP_OR_AM, 3'h0, 8'h24), ins(OP_COMPLEMENT_A, 3'h0, 8'h25), ins(OP_MOV_MA, 3'h0, 8'h26),
      ins(OP_ADD_AX, 3'h0, 8'hFF), ins(OP_ADD_AX, 3'h0, 8'h02), ins(OP_ADC_AM, 3'h0, 8'h20),
      ins(OP_SBC_AM, 3'h0, 8'h27), ins(OP_ADDM, 3'h0, 8'h28), ins(OP_SUB_AM, 3'h0, 8'h27),
      ins(OP_COMPLEMENT, 3'h0, 8'h20), ins(OP_INC_M, 3'h0, 8'h25), ins(OP_DEC_A, 3'h0, 8'h21),
      ins(OP_ADD_AM, 3'h0, 8'h27)};
    expv = {16'hF0FF, 16'hF700, 16'hB2FF, 16'hFA7F, 16'hFA0F, 16'h1100, 16'h1080, 16'h1080, 16'h1070,
      16'h1070, 16'h1100, 16'h1100, 16'hF0FF, 16'hF601, 16'hF411, 16'hB2FF, 16'hF2FF, 16'hF0ED,
      16'h10ED, 16'h11ED, 16'h10EF, 16'hF601};
    runTable;
    check("complement in memory", {8'h00, dmem[8'h20]}, 16'h00F0);
    check("increment in memory", {8'h00, dmem[8'h25]}, 16'h0000);
    check("decrement in memory", {8'h00, dmem[8'h23]}, 16'h00FF);
    check("move to memory", {8'h00, dmem[8'h26]}, 16'h0000);
    check("add to memory", {8'h00, dmem[8'h28]}, 16'h00EF);
    $display("arithmetic test done");
  endtask

  task rotBitTest;
    clearMem;
    dmem[8'h40] = 8'h81; dmem[8'h41] = 8'h01; dmem[8'h42] = 8'hA5; dmem[8'h43] = 8'h0F;
    code = {ins(OP_ROTATE, 3'h5, 8'h40), ins(OP_ROTATE, 3'h6, 8'h40), ins(OP_ROTATE, 3'h3, 8'h40),
      ins(OP_ROTATE, 3'h0, 8'h41), ins(OP_ROTATE, 3'h4, 8'h42), ins(OP_ROTATE, 3'h7, 8'h43),
      ins(OP_SET_BIT, 3'h4, 8'h42), ins(OP_CLR_BIT, 3'h0, 8'h43), ins(OP_ROTATE, 3'h2, 8'h41)};
    expv = {16'hF003, 16'hF240, 16'hF240, 16'hF240, 16'hF2D2, 16'hF01F, 16'hF01F, 16'hF01F, 16'hF01F};
    runTable;
    check("rotate memory left via carry", {8'h00, dmem[8'h40]}, 16'h0003);
    check("rotate memory right", {8'h00, dmem[8'h41]}, 16'h0040);
    check("bit set", {8'h00, dmem[8'h42]}, 16'h00B5);
    check("bit clear", {8'h00, dmem[8'h43]}, 16'h000E);
    $display("rotate and bit test done");
  endtask

  task skipTest;
    int cyc;
    logic [4:0] op [8] = '{OP_SKIP_BZ, OP_SKIP_BZ, OP_SKIP_BNZ, OP_SKIP_BNZ, OP_SKIP_INC, OP_SKIP_INC,
      OP_SKIP_DEC, OP_SKIP_DEC};
    logic [2:0] sub [8] = '{3'h3, 3'h0, 3'h7, 3'h7, 3'h0, 3'h0, 3'h0, 3'h0};
    logic [7:0] val [8] = '{8'hF7, 8'h01, 8'h80, 8'h7F, 8'hFF, 8'h05, 8'h01, 8'h10};
    logic [7:0] after [8] = '{8'hF7, 8'h01, 8'h80, 8'h7F, 8'h00, 8'h06, 8'h00, 8'h0F};
    logic taken [8] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
    for (int k = 0; k < 8; k++) begin
      clearMem;
      prog[1] = ins(op[k], sub[k], 8'h50);
      dmem[8'h50] = val[k];
      resetCore(2);
      waitDone(cyc);
      waitDone(cyc);
      check("skip length", cyc[15:0], taken[k] ? 16'h0008 : 16'h0004);
      check("skip target", {5'h00, pcOut}, taken[k] ? 16'h0003 : 16'h0002);
      @(posedge clk_sys);
      #1;
      check("skip operand", {8'h00, dmem[8'h50]}, {8'h00, after[k]});
    end
    $display("skip test done");
  endtask

  task haltTest;
    int n;
    int wdtStart;
    clearMem;
    prog[0] = ins(OP_MISC, 3'h0, {6'h00, MISC_CLRWDT});
    prog[1] = ins(OP_MISC, 3'h0, {6'h00, MISC_HALT});
    prog[2] = ins(OP_MOV_AX, 3'h0, 8'h5A);
    resetCore(2);
    wdtStart = wdtCount;
    n = 0;
    while (powerDown !== 1'b1 && n < 40) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    repeat (20) @(posedge clk_sys);
    #1;
    check("watchdog service pulses", 16'(wdtCount - wdtStart), 16'h0001);
    check("halted", {15'h0000, powerDown}, 16'h0001);
    check("halted counter", {5'h00, pcOut}, 16'h0002);
    check("halted accumulator", {8'h00, accOut}, 16'h0000);
    @(posedge clk_sys);
    wakeUp <= 1'b1;
    @(posedge clk_sys);
    wakeUp <= 1'b0;
    n = 0;
    while (accOut !== 8'h5A && n < 40) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    check("resumed accumulator", {8'h00, accOut}, 16'h005A);
    check("awake", {15'h0000, powerDown}, 16'h0000);
    $display("halt test done");
  endtask

  initial begin
    clearMem;
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    timingTest;
    arithTest;
    rotBitTest;
    skipTest;
    haltTest;
    stopTest;
  end
endmodule // mcu_instruction_execution_timing_tb
